// [inc/ppc_map.svh]
// register offsets, field positions and reset values of the pattern play
// configuration and error bank; assumes an 8-bit register address
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH

`define PPC_TRIG_CTRL_OFS      8'h44
`define PPC_SYNTH_CTRL_OFS     8'h45
`define PPC_MERGE_CTRL_OFS     8'h47
`define PPC_OUTPUT_START_DELAY_OFS      8'h5C
`define PPC_FIRST_ADDR_OFS     8'h5D
`define PPC_LAST_ADDR_OFS      8'h5E
`define PPC_CYCLE_CNT_OFS      8'h5F
`define PPC_ERR_OFS            8'h60

`define PPC_FIRST_ONLY_BIT     1
`define PPC_TW_MEM_BIT         0
`define PPC_ERR_CLEAR_BIT      15
`define PPC_ERR_PAT_DLY_BIT    4
`define PPC_ERR_DOUT_BIT       3
`define PPC_ERR_PERIOD_BIT     2
`define PPC_ERR_ODD_BIT        1
`define PPC_ERR_MEM_BIT        0
`define PPC_ADDR_LSB           4

`define PPC_OUTPUT_START_DELAY_RST      16'h0000
`define PPC_ADDR_RST           16'h0000
`define PPC_CYCLE_CNT_RST      16'h0001
`define PPC_SHIFT_LAST         5'h10
`define PPC_PAT_DLY_DEFAULT    16'h000E
`define PPC_DOUT_DEFAULT       16'h000E

`endif

// [inc/ppc_pkg.sv]
// types shared by the pattern play configuration bank
// assumes the register map header is compiled alongside
package ppc_pkg;
  typedef enum logic [1:0] {
    PPC_IDLE  = 2'b00,
    PPC_DELAY = 2'b01,
    PPC_PLAY  = 2'b10,
    PPC_WAIT  = 2'b11
  } ppc_state_t;
endpackage

// [design/ppc_merge.sv]
// merge of a 14-bit pattern memory word into the 24-bit tuning word
// assumes the caller registers the result
`timescale 1ns/1ns
`include "ppc_map.svh"
module ppc_merge (
  input  wire logic [23:0] base_word,
  input  wire logic [13:0] mem_word,
  input  wire logic [4:0]  shift,
  output logic      [23:0] merged
);
  logic [23:0] keep_mask;
  logic [23:0] placed;

  always_comb begin
    keep_mask = ~(24'hFFFFFF >> shift);
    placed    = {mem_word, 10'h000} >> shift;
    // reserved codes leave the programmed word untouched
    if (shift > `PPC_SHIFT_LAST) begin
      merged = base_word;
    end else begin
      merged = (base_word & keep_mask) | placed;
    end
  end
endmodule

// [design/ppc_play.sv]
// pattern play configuration registers, error flags and playback sequencer
// assumes pattern period, pattern delay and output start come from adjacent
// register banks, and that memory conflicts and sine wraps arrive as pulses
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
`include "ppc_map.svh"

module ppc_play #(
  parameter int AW = 12
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [15:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [15:0]   reg_rdata,
  input  wire logic          play_en,
  input  wire logic          sine_mode,
  input  wire logic [15:0]   pattern_period,
  input  wire logic [15:0]   pattern_delay,
  input  wire logic [15:0]   dout_start,
  input  wire logic          mem_conflict,
  input  wire logic          sine_wrap,
  input  wire logic [13:0]   mem_data,
  input  wire logic [23:0]   base_tuning_word,
  output logic      [AW-1:0] mem_addr,
  output logic               mem_rd,
  output logic               out_active,
  output logic      [23:0]   synth_tuning_word,
  output logic      [5:0]    error_flags
);

  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  if (AW < 1 || AW > 12) begin : g_bad_aw
    $error("ppc_play: AW must lie between 1 and 12");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    ppc_pkg::ppc_state_t st;
    logic [15:0]         output_start_delay;
    logic [15:0]         first_addr;
    logic [15:0]         last_addr;
    logic [15:0]         cycle_cnt;
    logic                first_only;
    logic                tw_mem;
    logic [4:0]          shift;
    logic [5:0]          flags;
    logic [15:0]         rdata;
    logic [15:0]         per_cnt;
    logic [15:0]         dly_cnt;
    logic [15:0]         sine_cnt;
    logic                first_done;
    logic [AW-1:0]       addr;
    logic                rd;
    logic                active;
    logic [23:0]         tw;
  } ppc_regs_t;

  ppc_regs_t r;
  ppc_regs_t next_r;

  logic [23:0]   merged;
  logic [AW-1:0] first_idx;
  logic [AW-1:0] last_idx;
  logic [AW:0]   pat_len;
  logic [17:0]   play_need;
  logic          period_start;
  logic          delay_due;
  logic [5:0]    events;

  // ------------------------------------------------------------
  // tuning word merge
  // ------------------------------------------------------------
  ppc_merge u_merge (
    .base_word (base_tuning_word),
    .mem_word  (mem_data),
    .shift     (r.shift),
    .merged    (merged)
  );

  // ------------------------------------------------------------
  // derived conditions
  // ------------------------------------------------------------
  always_comb begin
    first_idx = r.first_addr[`PPC_ADDR_LSB +: AW];
    last_idx  = r.last_addr[`PPC_ADDR_LSB +: AW];
    // a reversed range wraps through the memory, as the address counter does
    pat_len   = {1'b0, last_idx - first_idx} + {{AW{1'b0}}, 1'b1};
    // delay plus samples; sine mode length is set by the synthesizer and not checked here
    play_need = {2'b00, r.output_start_delay} + {{(18-AW-1){1'b0}}, pat_len};
    period_start = play_en && (r.per_cnt == 16'h0000);
    delay_due    = !r.first_only || !r.first_done;
  end

  // ------------------------------------------------------------
  // error events
  // ------------------------------------------------------------
  always_comb begin
    events = 6'h00;
    events[`PPC_ERR_PAT_DLY_BIT] = pattern_delay < `PPC_PAT_DLY_DEFAULT;
    events[`PPC_ERR_DOUT_BIT]    = dout_start < `PPC_DOUT_DEFAULT;
    events[`PPC_ERR_PERIOD_BIT]  = play_en && !sine_mode
                                   && (play_need > {2'b00, pattern_period});
    events[`PPC_ERR_ODD_BIT]     = play_en && !sine_mode && r.first_only
                                   && pat_len[0];
    events[`PPC_ERR_MEM_BIT]     = mem_conflict && r.rd;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        `PPC_TRIG_CTRL_OFS: begin
          next_r.first_only = reg_wdata[`PPC_FIRST_ONLY_BIT];
        end
        `PPC_SYNTH_CTRL_OFS: begin
          next_r.tw_mem = reg_wdata[`PPC_TW_MEM_BIT];
        end
        `PPC_MERGE_CTRL_OFS: begin
          next_r.shift = reg_wdata[4:0];
        end
        `PPC_OUTPUT_START_DELAY_OFS: begin
          next_r.output_start_delay = reg_wdata;
        end
        `PPC_FIRST_ADDR_OFS: begin
          next_r.first_addr = reg_wdata;
        end
        `PPC_LAST_ADDR_OFS: begin
          next_r.last_addr = reg_wdata;
        end
        `PPC_CYCLE_CNT_OFS: begin
          next_r.cycle_cnt = reg_wdata;
        end
        default: begin
        end
      endcase
    end

    // sticky flags; a new event wins over a clear in the same cycle
    if (reg_wr && reg_addr == `PPC_ERR_OFS && reg_wdata[`PPC_ERR_CLEAR_BIT]) begin
      next_r.flags = events;
    end else begin
      next_r.flags = r.flags | events;
    end

    // register reads, answered in the following cycle only
    next_r.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `PPC_TRIG_CTRL_OFS: begin
          next_r.rdata[`PPC_FIRST_ONLY_BIT] = r.first_only;
        end
        `PPC_SYNTH_CTRL_OFS: begin
          next_r.rdata[`PPC_TW_MEM_BIT] = r.tw_mem;
        end
        `PPC_MERGE_CTRL_OFS: begin
          next_r.rdata[4:0] = r.shift;
        end
        `PPC_OUTPUT_START_DELAY_OFS: begin
          next_r.rdata = r.output_start_delay;
        end
        `PPC_FIRST_ADDR_OFS: begin
          next_r.rdata = r.first_addr;
        end
        `PPC_LAST_ADDR_OFS: begin
          next_r.rdata = r.last_addr;
        end
        `PPC_CYCLE_CNT_OFS: begin
          next_r.rdata = r.cycle_cnt;
        end
        `PPC_ERR_OFS: begin
          next_r.rdata[5:0] = r.flags;
        end
        default: begin
        end
      endcase
    end

    // pattern period counter
    if (!play_en || r.per_cnt + 16'h0001 >= pattern_period) begin
      next_r.per_cnt = 16'h0000;
    end else begin
      next_r.per_cnt = r.per_cnt + 16'h0001;
    end

    // sequencer
    case (r.st)
      ppc_pkg::PPC_IDLE, ppc_pkg::PPC_WAIT: begin
        if (period_start) begin
          next_r.sine_cnt = 16'h0000;
          next_r.dly_cnt  = 16'h0000;
          next_r.addr     = first_idx;
          if (delay_due && r.output_start_delay != 16'h0000) begin
            next_r.st = ppc_pkg::PPC_DELAY;
          end else begin
            next_r.st         = ppc_pkg::PPC_PLAY;
            next_r.first_done = 1'b1;
          end
        end
      end
      ppc_pkg::PPC_DELAY: begin
        // output starts output_start_delay cycles after entering PPC_DELAY, one cycle more after the period begins
        if (r.dly_cnt + 16'h0001 >= r.output_start_delay) begin
          next_r.st         = ppc_pkg::PPC_PLAY;
          next_r.first_done = 1'b1;
        end else begin
          next_r.dly_cnt = r.dly_cnt + 16'h0001;
        end
      end
      ppc_pkg::PPC_PLAY: begin
        if (sine_mode) begin
          if (sine_wrap) begin
            next_r.sine_cnt = r.sine_cnt + 16'h0001;
            if (r.sine_cnt + 16'h0001 >= r.cycle_cnt) begin
              next_r.st = ppc_pkg::PPC_WAIT;
            end
          end
        end else if (r.addr == last_idx) begin
          next_r.st = ppc_pkg::PPC_WAIT;
        end else begin
          next_r.addr = r.addr + {{(AW-1){1'b0}}, 1'b1};
        end
      end
      default: begin
        next_r.st = ppc_pkg::PPC_IDLE;
      end
    endcase

    // leaving play mode rearms the first-pattern delay
    if (!play_en) begin
      next_r.st         = ppc_pkg::PPC_IDLE;
      next_r.first_done = 1'b0;
    end

    next_r.active = next_r.st == ppc_pkg::PPC_PLAY;
    next_r.rd     = next_r.active && !sine_mode;
    next_r.tw     = r.tw_mem ? merged : base_tuning_word;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r            <= '0;
      r.st         <= ppc_pkg::PPC_IDLE;
      r.output_start_delay  <= `PPC_OUTPUT_START_DELAY_RST;
      r.first_addr <= `PPC_ADDR_RST;
      r.last_addr  <= `PPC_ADDR_RST;
      r.cycle_cnt  <= `PPC_CYCLE_CNT_RST;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ------------------------------------------------------------
  assign reg_rdata         = r.rdata;
  assign mem_addr          = r.addr;
  assign mem_rd            = r.rd;
  assign out_active        = r.active;
  assign synth_tuning_word = r.tw;
  assign error_flags       = r.flags;

endmodule

// [sim/ppc_play_properties.sv]
// port assertions for the pattern play configuration bank
// assumes ppc_map.svh on the include path; bound to every ppc_play
`timescale 1ns/1ns
`include "ppc_map.svh"
module ppc_play_properties #(
  parameter int AW = 12
) (
  input wire logic          core_clk,
  input wire logic          rst,
  input wire logic [7:0]    reg_addr,
  input wire logic [15:0]   reg_wdata,
  input wire logic          reg_wr,
  input wire logic [15:0]   pattern_delay,
  input wire logic [15:0]   dout_start,
  input wire logic          mem_conflict,
  input wire logic          play_en,
  input wire logic          sine_mode,
  input wire logic [AW-1:0] mem_addr,
  input wire logic          mem_rd,
  input wire logic          out_active,
  input wire logic [5:0]    error_flags
);
  // ----------------------------------------
  // shadow of the readout window
  // ----------------------------------------
  logic [AW-1:0] first_q;
  logic [AW-1:0] last_q;
  wire           clr = reg_wr && reg_addr == `PPC_ERR_OFS && reg_wdata[`PPC_ERR_CLEAR_BIT];
  always_ff @(posedge core_clk) begin
    if (rst) begin
      first_q <= '0;
      last_q  <= '0;
    end else if (reg_wr && reg_addr == `PPC_FIRST_ADDR_OFS) begin
      first_q <= reg_wdata[`PPC_ADDR_LSB +: AW];
    end else if (reg_wr && reg_addr == `PPC_LAST_ADDR_OFS) begin
      last_q  <= reg_wdata[`PPC_ADDR_LSB +: AW];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_PAT_DLY: assert property (pattern_delay < `PPC_PAT_DLY_DEFAULT |=> error_flags[4])
    else $error("pattern delay flag missing");
  AST_DOUT: assert property (dout_start < `PPC_DOUT_DEFAULT |=> error_flags[3])
    else $error("output start flag missing");
  AST_STICKY: assert property (!clr |=> (error_flags & $past(error_flags)) == $past(error_flags))
    else $error("error flag dropped without clear");
  AST_CLEAR: assert property (clr && pattern_delay >= `PPC_PAT_DLY_DEFAULT && dout_start >= `PPC_DOUT_DEFAULT
    |=> error_flags[4:3] == 2'h0) else $error("clear left flags set");
  AST_MEM_ERR: assert property (mem_conflict && mem_rd |=> error_flags[0])
    else $error("memory read flag missing");
  AST_FIRST: assert property ($rose(mem_rd) |-> mem_addr == first_q)
    else $error("readout began at wrong address");
  AST_STEP: assert property (mem_rd && $past(mem_rd) |-> mem_addr == AW'($past(mem_addr) + 1'b1))
    else $error("readout address did not step");
  AST_LAST: assert property (mem_rd && !sine_mode && mem_addr == last_q |=> !mem_rd)
    else $error("readout ran past last address");
  AST_STOP: assert property (!play_en |=> !out_active && !mem_rd)
    else $error("output active without playback");
endmodule

bind ppc_play ppc_play_properties #(.AW(AW)) i_ppc_play_properties (.core_clk, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .pattern_delay, .dout_start, .mem_conflict, .play_en, .sine_mode, .mem_addr, .mem_rd, .out_active,
  .error_flags);

// [sim/ppc_play_bench.sv]
// self-checking bench for the pattern play configuration bank
// assumes ppc_map.svh on the include path and the bound checker
`timescale 1ns/1ns
`include "ppc_map.svh"
module ppc_play_bench;
  logic        core_clk = 1'b0;
  logic        rst, reg_wr, reg_rd, play_en, sine_mode, mem_conflict, sine_wrap, mem_rd, out_active;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, pattern_period, pattern_delay, dout_start;
  logic [13:0] mem_data;
  logic [23:0] base_tuning_word, synth_tuning_word;
  logic [11:0] mem_addr;
  logic [5:0]  error_flags;
  logic [31:0] seed = 32'h000126CB;
  logic [31:0] d;
  int          mismatches, n_checks, cyc, n, g;
  // ----------------------------------------
  // clock, design and helpers
  // ----------------------------------------
  always #50 core_clk = ~core_clk;
  ppc_play i_ppc_play (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .play_en, .sine_mode,
    .pattern_period, .pattern_delay, .dout_start, .mem_conflict, .sine_wrap, .mem_data, .base_tuning_word,
    .mem_addr, .mem_rd, .out_active, .synth_tuning_word, .error_flags);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // bit by bit for s up to 16: the top s bits keep the base word, the memory word sits below them, zeros fill the rest
  function automatic logic [23:0] merge(input logic [23:0] b, input logic [13:0] m, input int s);
    logic [23:0] w;
    w = b;
    if (s <= 16) begin
      for (int i = 0; i < 24; i++) begin
        if (i < 24 - s) w[i] = (i + s >= 10) ? m[i + s - 10] : 1'b0;
      end
    end
    return w;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // an idle edge after each strobe keeps the driver from assigning it twice at once
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 cmp({8'h00, reg_rdata}, {8'h00, e});
    @(posedge core_clk);
  endtask
  // outputs read at the edge hold the value settled in the previous cycle
  task automatic wait_out(input logic v);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (out_active !== v && n < 200);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      finish_test();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {rst, reg_wr, reg_rd, play_en, sine_mode, mem_conflict, sine_wrap} = 7'h40;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    pattern_period = 16'h0010;
    pattern_delay = `PPC_PAT_DLY_DEFAULT;
    dout_start = `PPC_DOUT_DEFAULT;
    mem_data = 14'h0000;
    base_tuning_word = 24'h000000;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (int a = 8'h5C; a <= 8'h5F; a++) begin
      d = rnd();
      wr(8'(a), d[15:0]);
      rd(8'(a), d[15:0]);
    end
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(`PPC_OUTPUT_START_DELAY_OFS, 16'h0000);
    rd(`PPC_CYCLE_CNT_OFS, 16'h0001);
    wr(8'h61, 16'hFFFF);
    rd(8'h61, 16'h0000);
    pattern_delay <= 16'h0005;
    dout_start <= 16'h0003;
    @(posedge core_clk);
    pattern_delay <= `PPC_PAT_DLY_DEFAULT;
    dout_start <= `PPC_DOUT_DEFAULT;
    rd(`PPC_ERR_OFS, 16'h0018);
    wr(`PPC_ERR_OFS, 16'h8000);
    rd(`PPC_ERR_OFS, 16'h0000);
    wr(`PPC_OUTPUT_START_DELAY_OFS, 16'h0002);
    wr(`PPC_FIRST_ADDR_OFS, 16'h0100);
    wr(`PPC_LAST_ADDR_OFS, 16'h0110);
    for (int f = 0; f < 2; f++) begin
      wr(`PPC_TRIG_CTRL_OFS, f ? 16'h0002 : 16'h0000);
      rd(`PPC_TRIG_CTRL_OFS, f ? 16'h0002 : 16'h0000);
      play_en <= 1'b1;
      wait_out(1'b1);
      // period start edge, two delay edges, then the edge that shows the output
      cmp(24'(n), 24'h000004);
      cmp({12'h000, mem_addr}, 24'h000010);
      @(posedge core_clk);
      cmp({12'h000, mem_addr}, 24'h000011);
      wait_out(1'b0);
      g = n + 1;
      wait_out(1'b1);
      cmp(24'(g + n), f ? 24'h00000E : 24'h000010);
      mem_conflict <= 1'b1;
      @(posedge core_clk);
      mem_conflict <= 1'b0;
      play_en <= 1'b0;
      @(posedge core_clk);
    end
    wr(`PPC_LAST_ADDR_OFS, 16'h0120);
    pattern_period <= 16'h0002;
    play_en <= 1'b1;
    repeat (40) @(posedge core_clk);
    play_en <= 1'b0;
    pattern_period <= 16'h0010;
    rd(`PPC_ERR_OFS, 16'h0007);
    wr(`PPC_LAST_ADDR_OFS, 16'h0110);
    wr(`PPC_ERR_OFS, 16'h8000);
    rd(`PPC_ERR_OFS, 16'h0000);
    wr(`PPC_TRIG_CTRL_OFS, 16'h0000);
    wr(`PPC_CYCLE_CNT_OFS, 16'h0003);
    sine_mode <= 1'b1;
    play_en <= 1'b1;
    wait_out(1'b1);
    repeat (3) begin
      cmp({23'h000000, out_active}, 24'h000001);
      sine_wrap <= 1'b1;
      @(posedge core_clk);
      sine_wrap <= 1'b0;
      @(posedge core_clk);
    end
    @(posedge core_clk);
    cmp({23'h000000, out_active}, 24'h000000);
    play_en <= 1'b0;
    sine_mode <= 1'b0;
    wr(`PPC_SYNTH_CTRL_OFS, 16'h0001);
    for (int s = 0; s <= 17; s++) begin
      base_tuning_word <= 24'(rnd());
      mem_data <= 14'(rnd());
      wr(`PPC_MERGE_CTRL_OFS, 16'(s));
      repeat (2) @(posedge core_clk);
      cmp(synth_tuning_word, merge(base_tuning_word, mem_data, s));
      rd(`PPC_MERGE_CTRL_OFS, 16'(s));
    end
    finish_test();
  end
endmodule
